//--- logic/acs_sequencer.sv
`timescale 1ns/10ps
// What this block does
// RULE1 - restart pin high aborts the conversion and restarts the filter
// RULE2 - restart pin falling drives result_ready_n high for the conversion
// RULE3 - after settling, result_ready_n falls; first result already settled
// RULE4 - host writes input select on ready, then restart and resume commands
// RULE5 - read after channel change returns the previous conversion result
// RULE6 - input select: positive channel upper nibble, negative lower nibble
// RULE7 - channel write takes one cycle so cycling throughput is not slowed
// RULE8 - resume from low-power idle starts a one-shot conversion with settling
// RULE9 - host re-enters low-power idle after each one-shot read
// RULE10 - after restart, channel change or resume, conversion runs continuously
// RULE11 - ready falling edges are spaced one output data period apart
// RULE12 - input step settles within 5, 3, 2 or 1 ready periods by rate
// RULE13 - host restarts or discards the first result after an input step
// RULE14 - results are 24-bit two's complement words
// RULE15 - results clip at 7FFFFF and 800000 beyond full scale
// RULE16 - zero gives 000000, plus one LSB 000001, minus one LSB FFFFFF
// RULE17 - settling interval depends on the rate, 0.21 ms at the fastest
// RULE18 - rate select sets averaging count and output data rate
// RULE19 - every interval is counted in master clock cycles
module acs_sequencer #(
  // right shift on settle and period counts, simulation only
  parameter int TIME_SHIFT = 0
) (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic                              restart_powerdown_pin,
  input  wire acs_pkg::acs_cmd_s                 cmd,
  output logic                                   cmd_ready,
  input  wire logic signed [acs_pkg::RAW_W-1:0]  analog_level,
  output logic                                   result_ready_n,
  output logic                                   read_valid,
  output logic [acs_pkg::DATA_W-1:0]             read_data,
  input  wire logic                              read_ready,
  output acs_pkg::acs_mux_s                      input_select_register,
  output logic [7:0]                             rate_select_register,
  output logic                                   converting,
  output logic                                   fully_settled
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_HOLD   = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_RUN    = 4'b1000
  } acs_state_e;

  acs_state_e        state;
  acs_state_e        next_state;
  logic [CNT_W-1:0]  timer;
  logic [CNT_W-1:0]  next_timer;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic              next_result_ready_n;
  logic [3:0]        rate_idx;
  logic [3:0]        next_rate_idx;
  logic [7:0]        next_rate_select;
  acs_mux_s          next_input_select;
  logic [2:0]        step_left;
  logic [2:0]        next_step_left;
  logic              next_converting;
  logic              next_fully_settled;
  logic              pin_level;
  logic              pin_prev;
  logic              cmd_take;
  logic              push;
  logic              buf_in_ready;
  logic [4:0]        rate_hit;
  logic [CNT_W-1:0]  settle_load;
  logic [CNT_W-1:0]  period_load;
  logic [DATA_W-1:0] sample_code;

  // ----------------------------------------------------------------
  // pin input and result buffer
  // ----------------------------------------------------------------
  acs_pin_sync u_pin_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .pin     (restart_powerdown_pin),
    .level   (pin_level)
  );

  acs_skid_buffer u_buffer (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (push),
    .in_data   (result),
    .in_ready  (buf_in_ready),
    .out_valid (read_valid),
    .out_data  (read_data),
    .out_ready (read_ready)
  );

  // commands stall while the buffer is full, so no read is lost
  assign cmd_ready = buf_in_ready;
  assign cmd_take  = cmd.valid & buf_in_ready;
  assign rate_hit  = acs_rate_lookup(cmd.data);

  // ----------------------------------------------------------------
  // timing loads
  // ----------------------------------------------------------------
  // RULE17 RULE19 settle from table
  // never below one cycle, even with a large simulation shift
  always_comb begin
    settle_load = acs_settle_cycles(rate_idx) >> TIME_SHIFT;
    if (settle_load == CNT_ZERO) begin
      settle_load = CNT_ONE;
    end
  end

  // RULE11 RULE18 period from averaging
  always_comb begin
    period_load = acs_period_cycles(rate_idx) >> TIME_SHIFT;
    if (period_load < CNT_TWO) begin
      period_load = CNT_TWO;
    end
  end

  // ----------------------------------------------------------------
  // result formatting
  // ----------------------------------------------------------------
  // RULE14 RULE15 RULE16 clip to 24 bits
  always_comb begin
    sample_code = analog_level[DATA_W-1:0];
    if (analog_level >= $signed({{(RAW_W-DATA_W){1'b0}}, CODE_POS_FS})) begin
      sample_code = CODE_POS_FS;
    end else if (analog_level <= $signed({{(RAW_W-DATA_W){1'b1}}, CODE_NEG_FS})) begin
      sample_code = CODE_NEG_FS;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_timer          = timer;
    next_result         = result;
    next_result_ready_n = result_ready_n;
    next_rate_idx       = rate_idx;
    next_rate_select    = rate_select_register;
    next_input_select   = input_select_register;
    next_step_left      = step_left;
    next_fully_settled  = fully_settled;
    push                = 1'b0;

    if (cmd_take) begin
      case (cmd.code)
        ACS_CMD_RDATA: begin
          // RULE5 last stored result
          push = 1'b1;
        end
        ACS_CMD_WRITE_MUX: begin
          // RULE6 RULE7 nibble split
          next_input_select.positive_input = cmd.data[7:4];
          next_input_select.negative_input = cmd.data[3:0];
          // RULE12 step counted in periods
          next_step_left     = STEP_PERIODS[rate_idx];
          next_fully_settled = 1'b0;
        end
        ACS_CMD_WRITE_RATE: begin
          // codes outside the table are ignored
          if (rate_hit[4]) begin
            next_rate_select = cmd.data;
            next_rate_idx    = rate_hit[3:0];
          end
        end
        default: begin
        end
      endcase
    end

    case (state)
      ST_IDLE, ST_HOLD: begin
        // RULE8 resume starts settling
        if (cmd_take && cmd.code == ACS_CMD_WAKEUP) begin
          next_state          = ST_SETTLE;
          next_timer          = settle_load;
          next_result_ready_n = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (timer == CNT_ONE) begin
          // RULE3 settled first result
          next_state          = ST_RUN;
          next_timer          = period_load;
          next_result         = sample_code;
          next_result_ready_n = 1'b0;
          next_step_left      = STEP_ZERO;
          next_fully_settled  = 1'b1;
        end else begin
          next_timer = timer - CNT_ONE;
        end
      end
      ST_RUN: begin
        // RULE10 RULE11 continuous results
        if (timer == CNT_ONE) begin
          next_timer          = period_load;
          next_result         = sample_code;
          next_result_ready_n = 1'b0;
          // RULE12 one step per result
          if (next_step_left != STEP_ZERO) begin
            next_step_left = next_step_left - 3'h1;
          end
          next_fully_settled = (next_step_left == STEP_ZERO);
        end else begin
          next_timer = timer - CNT_ONE;
          // brief high so every new result shows a falling edge
          if (timer == CNT_TWO) begin
            next_result_ready_n = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    if (cmd_take && state != ST_IDLE) begin
      if (cmd.code == ACS_CMD_SYNC) begin
        next_state = ST_HOLD;
      end
    end
    if (cmd_take && cmd.code == ACS_CMD_STANDBY) begin
      next_state = ST_IDLE;
    end

    // RULE1 pin wins over commands
    if (pin_level) begin
      // aborted, so no result may land while held
      next_state          = ST_HOLD;
      next_result         = result;
      next_result_ready_n = result_ready_n;
    end else if (pin_prev) begin
      // RULE2 ready high on fall
      next_state          = ST_SETTLE;
      next_timer          = settle_load;
      next_result_ready_n = 1'b1;
    end
  end

  assign next_converting = (next_state == ST_SETTLE) | (next_state == ST_RUN);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state                 <= ST_IDLE;
      timer                 <= CNT_ZERO;
      result                <= RESULT_ZERO;
      result_ready_n        <= 1'b1;
      rate_idx              <= RIDX_RESET;
      rate_select_register  <= RATE_RESET;
      input_select_register <= MUX_RESET;
      step_left             <= STEP_ZERO;
      fully_settled         <= 1'b0;
      converting            <= 1'b0;
      pin_prev              <= 1'b0;
    end else begin
      state                 <= next_state;
      timer                 <= next_timer;
      result                <= next_result;
      result_ready_n        <= next_result_ready_n;
      rate_idx              <= next_rate_idx;
      rate_select_register  <= next_rate_select;
      input_select_register <= next_input_select;
      step_left             <= next_step_left;
      fully_settled         <= next_fully_settled;
      converting            <= next_converting;
      pin_prev              <= pin_level;
    end
  end

endmodule

//--- logic/acs_pkg.sv
package acs_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int                 DATA_W      = 24;
  localparam int                 CNT_W       = 24;
  localparam int                 CHAN_W      = 4;
  localparam int                 RAW_W       = 32;
  localparam int                 RATE_NUM    = 16;
  localparam logic [7:0]         RATE_RESET  = 8'hF0;
  localparam logic [3:0]         RIDX_RESET  = 4'h0;
  localparam logic [7:0]         MUX_RESET   = 8'h01;
  localparam logic [DATA_W-1:0]  RESULT_ZERO = 24'h000000;
  localparam logic [DATA_W-1:0]  CODE_POS_FS = 24'h7FFFFF;
  localparam logic [DATA_W-1:0]  CODE_NEG_FS = 24'h800000;
  localparam logic [CNT_W-1:0]   CNT_ZERO    = 24'h000000;
  localparam logic [CNT_W-1:0]   CNT_ONE     = 24'h000001;
  localparam logic [CNT_W-1:0]   CNT_TWO     = 24'h000002;
  localparam logic [2:0]         STEP_ZERO   = 3'h0;

  // ----------------------------------------------------------------
  // timing, in master clock cycles; settle table given in microseconds
  // ----------------------------------------------------------------
  // one averager slot is 256 master clocks (nominal 7.68 MHz / 30 kSPS)
  localparam longint MOD_CYCLES  = 256;
  localparam longint NOMINAL_KHZ = 7680;
  localparam longint US_PER_MS   = 1000;

  localparam logic [7:0] RATE_CODE [RATE_NUM] = '{
    8'hF0, 8'hE0, 8'hD0, 8'hC0, 8'hB0, 8'hA1, 8'h92, 8'h82,
    8'h72, 8'h63, 8'h53, 8'h43, 8'h33, 8'h23, 8'h13, 8'h03};
  localparam longint NUM_AVE [RATE_NUM] = '{
    1, 2, 4, 8, 15, 30, 60, 300, 500, 600, 1000, 1200, 2000, 3000, 6000, 12000};
  // settling interval in microseconds at the nominal master clock
  localparam longint SETTLE_US [RATE_NUM] = '{
    210, 250, 310, 440, 680, 1180, 2180, 10180,
    16840, 20180, 33510, 40180, 66840, 100180, 200180, 400180};
  localparam logic [2:0] STEP_PERIODS [RATE_NUM] = '{
    3'h5, 3'h3, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
    3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};

  // ----------------------------------------------------------------
  // commands and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACS_CMD_WAKEUP     = 3'h0,
    ACS_CMD_SYNC       = 3'h1,
    ACS_CMD_STANDBY    = 3'h2,
    ACS_CMD_RDATA      = 3'h3,
    ACS_CMD_WRITE_MUX  = 3'h4,
    ACS_CMD_WRITE_RATE = 3'h5
  } acs_cmd_e;

  typedef struct packed {
    logic       valid;
    acs_cmd_e   code;
    logic [7:0] data;
  } acs_cmd_s;

  typedef struct packed {
    logic [CHAN_W-1:0] positive_input;
    logic [CHAN_W-1:0] negative_input;
  } acs_mux_s;

  // ----------------------------------------------------------------
  // lookups
  // ----------------------------------------------------------------
  function automatic logic [4:0] acs_rate_lookup(input logic [7:0] code);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < RATE_NUM; i++) begin
      if (RATE_CODE[i] == code) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [CNT_W-1:0] acs_period_cycles(input logic [3:0] idx);
    return CNT_W'(NUM_AVE[idx] * MOD_CYCLES);
  endfunction

  // least time, so round up
  function automatic logic [CNT_W-1:0] acs_settle_cycles(input logic [3:0] idx);
    return CNT_W'((SETTLE_US[idx] * NOMINAL_KHZ + US_PER_MS - 1) / US_PER_MS);
  endfunction

endpackage

//--- logic/acs_pin_sync.sv
`timescale 1ns/10ps
module acs_pin_sync (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_level;

  // ----------------------------------------------------------------
  // three stages, change taken when two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    next_level = level;
    if (stage2 == stage3) begin
      next_level = stage3;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level  <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

endmodule

//--- logic/acs_skid_buffer.sv
`timescale 1ns/10ps
module acs_skid_buffer (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic                        in_valid,
  input  wire logic [acs_pkg::DATA_W-1:0]  in_data,
  output logic                             in_ready,
  output logic                             out_valid,
  output logic [acs_pkg::DATA_W-1:0]       out_data,
  input  wire logic                        out_ready
);
  import acs_pkg::*;

  logic              full;
  logic [DATA_W-1:0] tail;
  logic              next_head_v;
  logic              next_full;
  logic [DATA_W-1:0] next_head;
  logic [DATA_W-1:0] next_tail;
  logic              pop;
  logic              push;

  // ----------------------------------------------------------------
  // two slots, head is always the output word
  // ----------------------------------------------------------------
  // head sits in a flop so the top output needs no extra stage
  always_comb begin
    pop         = out_valid & out_ready;
    push        = in_valid & ~full;
    next_head_v = out_valid;
    next_full   = full;
    next_head   = out_data;
    next_tail   = tail;
    if (pop) begin
      next_head_v = full;
      next_head   = tail;
      next_full   = 1'b0;
    end
    if (push) begin
      if (!next_head_v) begin
        next_head_v = 1'b1;
        next_head   = in_data;
      end else begin
        next_full = 1'b1;
        next_tail = in_data;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      full      <= 1'b0;
      out_data  <= RESULT_ZERO;
      tail      <= RESULT_ZERO;
      in_ready  <= 1'b1;
    end else begin
      out_valid <= next_head_v;
      full      <= next_full;
      out_data  <= next_head;
      tail      <= next_tail;
      in_ready  <= ~next_full;
    end
  end

endmodule

//--- verif/acs_sequencer_assertions.sv
`timescale 1ns/10ps
module acs_chk #(
  parameter int TIME_SHIFT = 4
) (
  input wire logic                      ref_clk,
  input wire logic                      reset_n,
  input wire logic                      restart_powerdown_pin,
  input wire acs_pkg::acs_cmd_s         cmd,
  input wire logic                      cmd_ready,
  input wire logic                      result_ready_n,
  input wire logic                      read_valid,
  input wire logic [acs_pkg::DATA_W-1:0] read_data,
  input wire logic                      read_ready,
  input wire acs_pkg::acs_mux_s         input_select_register,
  input wire logic [7:0]                rate_select_register,
  input wire logic                      converting,
  input wire logic                      fully_settled
);
  import acs_pkg::*;
  localparam int PER = 256 >> TIME_SHIFT;
  localparam int SLO = 1613 >> TIME_SHIFT;
  localparam int SHI = SLO + 10;
  // ----
  // helpers
  // ----
  logic        rdy_q, next_rdy_q, quiet, next_quiet;
  logic [15:0] gap, next_gap;
  logic [4:0]  ph, next_ph;
  // pin synchroniser lag, so commands near a pin change are skipped
  wire busy = restart_powerdown_pin | (|ph);
  wire fall = rdy_q & ~result_ready_n;
  wire take = cmd.valid & cmd_ready & ~busy;
  always_comb begin
    next_rdy_q = result_ready_n;
    next_ph = {ph[3:0], restart_powerdown_pin};
    next_gap = fall ? 16'h0000 : gap + 16'h0001;
    next_quiet = (fall | quiet) & converting & ~busy & (rate_select_register == 8'hF0)
                 & ~(cmd.valid & (cmd.code != ACS_CMD_RDATA));
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_q <= 1'b1;
      ph <= 5'h00;
      gap <= 16'h0000;
      quiet <= 1'b0;
    end else begin
      rdy_q <= next_rdy_q;
      ph <= next_ph;
      gap <= next_gap;
      quiet <= next_quiet;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_period; fall && quiet |-> gap == 16'(PER - 1); endproperty
  property p_pin_hold; restart_powerdown_pin [*6] |-> !$fell(result_ready_n); endproperty
  property p_pin_fall; $fell(restart_powerdown_pin) |-> ##6 result_ready_n [*8]; endproperty
  property p_settle; $fell(restart_powerdown_pin) |-> ##[SLO:SHI] $fell(result_ready_n); endproperty
  sequence s_restart; $fell(restart_powerdown_pin) ##[SLO:SHI] $fell(result_ready_n); endsequence
  property p_first; s_restart |-> ##[0:1] fully_settled; endproperty
  property p_wake;
    take && cmd.code == ACS_CMD_WAKEUP && !converting |=> converting && result_ready_n;
  endproperty
  property p_standby; take && cmd.code == ACS_CMD_STANDBY && converting |=> !converting; endproperty
  property p_mux;
    take && cmd.code == ACS_CMD_WRITE_MUX |=> input_select_register == $past(cmd.data) && !fully_settled;
  endproperty
  property p_rdata; take && cmd.code == ACS_CMD_RDATA && !read_valid |=> read_valid; endproperty
  property p_hold; read_valid && !read_ready |=> read_valid && $stable(read_data); endproperty
  a_period: assert property (p_period)
    else $error("ready spacing wrong");
  a_pin_hold: assert property (p_pin_hold)
    else $error("result while pin high");
  a_pin_fall: assert property (p_pin_fall)
    else $error("ready low after pin fall");
  a_settle: assert property (p_settle)
    else $error("settle time wrong");
  a_first: assert property (p_first)
    else $error("first result not settled");
  a_wake: assert property (p_wake)
    else $error("resume did not start");
  a_standby: assert property (p_standby)
    else $error("idle not entered");
  a_mux: assert property (p_mux)
    else $error("input select wrong");
  a_rdata: assert property (p_rdata)
    else $error("read word missing");
  a_hold: assert property (p_hold)
    else $error("read word lost");
  c_pin: cover property ($fell(restart_powerdown_pin));
  c_full: cover property (cmd.valid && !cmd_ready);
  c_mux: cover property (take && cmd.code == ACS_CMD_WRITE_MUX);
endmodule
bind acs_sequencer acs_chk #(.TIME_SHIFT(TIME_SHIFT)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .restart_powerdown_pin(restart_powerdown_pin),
  .cmd(cmd), .cmd_ready(cmd_ready), .result_ready_n(result_ready_n),
  .read_valid(read_valid), .read_data(read_data), .read_ready(read_ready),
  .input_select_register(input_select_register), .rate_select_register(rate_select_register),
  .converting(converting), .fully_settled(fully_settled));

//--- verif/acs_host_model.sv
`timescale 1ns/10ps
module acs_host_model #(
  parameter int GAP = 2
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire acs_pkg::acs_cmd_s req,
  input  wire logic              stall,
  output logic                   idle,
  output acs_pkg::acs_cmd_s      cmd,
  input  wire logic              cmd_ready,
  output logic                   read_ready
);
  import acs_pkg::*;
  acs_cmd_s q[$];
  int       gap;
  // ----
  // command stream
  // ----
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd <= '0;
      gap = 0;
      idle <= 1'b1;
      read_ready <= 1'b0;
    end else begin
      if (req.valid) begin
        q.push_back(req);
      end
      idle <= (q.size() == 0) && !cmd.valid;
      read_ready <= ~stall;
      if (cmd.valid && cmd_ready) begin
        cmd.valid <= 1'b0;
        // stale data would hide a bad sample
        cmd.data <= ~cmd.data;
        gap = GAP;
      end else if (!cmd.valid && gap > 0) begin
        gap--;
      end else if (!cmd.valid && q.size() > 0) begin
        cmd <= q.pop_front();
      end
    end
  end
endmodule

//--- verif/acs_sequencer_bench.sv
`timescale 1ns/10ps
module acs_sequencer_bench;
  import acs_pkg::*;
  localparam int SH = 4;
  localparam int SET = 1613 >> SH;
  localparam int PER = 256 >> SH;
  localparam int STEP = 5;
  logic                    ref_clk = 1'b0;
  logic                    reset_n, pin, stall, read_ready, cmd_ready, idle;
  logic                    result_ready_n, read_valid, converting, fully_settled;
  logic                    rdy_q = 1'b1;
  logic [7:0]              rate_select_register;
  logic [DATA_W-1:0]       read_data;
  logic signed [RAW_W-1:0] analog_level;
  acs_cmd_s                req, cmd;
  acs_mux_s                input_select_register;
  logic [DATA_W-1:0]       exp_q[$];
  logic [15:0]             r;
  int                      error_cnt, checked, cyc, fall_cnt, fall_cyc;
  logic signed [RAW_W-1:0] tv [7] = '{32'sh00000000, 32'sh00000001, -32'sh00000001,
    32'sh007FFFFF, 32'sh01000000, -32'sh00800000, -32'sh00900000};
  always #20 ref_clk = ~ref_clk;
  acs_sequencer #(.TIME_SHIFT(SH)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .restart_powerdown_pin(pin), .cmd(cmd), .cmd_ready(cmd_ready), .analog_level(analog_level),
    .result_ready_n(result_ready_n), .read_valid(read_valid), .read_data(read_data),
    .read_ready(read_ready), .input_select_register(input_select_register),
    .rate_select_register(rate_select_register), .converting(converting), .fully_settled(fully_settled));
  acs_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .stall(stall), .idle(idle),
    .cmd(cmd), .cmd_ready(cmd_ready), .read_ready(read_ready));
  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [23:0] clip(input logic signed [31:0] v);
    if (v > 32'sh007FFFFF) return 24'h7FFFFF;
    if (v < -32'sh00800000) return 24'h800000;
    return v[23:0];
  endfunction
  task automatic test_done;
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_val(input logic [23:0] a, input logic [23:0] e);
    checked++;
    if (a !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t value %h expected %h", $time, a, e);
    end
  endtask
  task automatic cmp_cnt(input int n, input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("CHECK FAILED %0t count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task automatic send(input acs_cmd_e c, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, c, d};
    @(posedge ref_clk);
    req <= '0;
  endtask
  task automatic rdata(input logic [23:0] e);
    exp_q.push_back(e);
    send(ACS_CMD_RDATA, 8'h00);
  endtask
  task automatic wait_fall(output int fc);
    int f;
    f = fall_cnt;
    for (int i = 0; i < 3000 && fall_cnt == f; i++) @(posedge ref_clk);
    fc = fall_cyc;
  endtask
  task automatic wait_idle;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 300 && idle !== 1'b1; i++) @(posedge ref_clk);
  endtask
  // falls counted off the sampling edge, so waiters never race them
  always @(negedge ref_clk) begin
    cyc++;
    if (rdy_q === 1'b1 && result_ready_n === 1'b0) begin
      fall_cnt++;
      fall_cyc = cyc;
    end
    rdy_q = result_ready_n;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end
  always @(posedge ref_clk) begin
    if (read_valid === 1'b1 && read_ready === 1'b1) cmp_val(read_data, exp_q.pop_front());
  end
  // ----
  // scenarios
  // ----
  initial begin
    int n, t0;
    logic signed [RAW_W-1:0] av, old;
    reset_n <= 1'b0;
    pin <= 1'b0;
    stall <= 1'b0;
    req <= '0;
    analog_level <= '0;
    r = 16'h0034;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk) cmp_val({cmd_ready, result_ready_n, read_valid, converting, fully_settled,
      input_select_register, rate_select_register}, {5'b11000, 8'h01, 8'hF0});
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      r = lfsr(r);
      av = (i < 7) ? tv[i] : {{12{r[15]}}, r, 4'h5};
      analog_level <= av;
      send(ACS_CMD_WAKEUP, 8'h00);
      t0 = cyc;
      wait_fall(n);
      cmp_cnt(n - t0, SET, SET + 12);
      send(ACS_CMD_STANDBY, 8'h00);
      rdata(clip(av));
    end
    send(ACS_CMD_WAKEUP, 8'h00);
    wait_fall(t0);
    for (int k = 0; k < 3; k++) begin
      wait_fall(n);
      cmp_cnt(n - t0, PER, PER);
      t0 = n;
    end
    pin <= 1'b1;
    av = 32'sh00123456;
    analog_level <= av;
    n = fall_cnt;
    repeat (40) @(posedge ref_clk);
    cmp_cnt(fall_cnt - n, 0, 0);
    pin <= 1'b0;
    t0 = cyc;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) cmp_val(result_ready_n, 1'b1);
    wait_fall(n);
    cmp_cnt(n - t0, SET, SET + 12);
    @(negedge ref_clk) cmp_val(fully_settled, 1'b1);
    rdata(clip(av));
    wait_fall(t0);
    old = av;
    r = lfsr(r);
    av = {{12{r[15]}}, r, 4'hC};
    analog_level <= av;
    send(ACS_CMD_WRITE_MUX, 8'h23);
    send(ACS_CMD_SYNC, 8'h00);
    send(ACS_CMD_WAKEUP, 8'h00);
    rdata(clip(old));
    wait_fall(n);
    cmp_cnt(n - t0, SET, SET + 24);
    @(negedge ref_clk) cmp_val(input_select_register, 8'h23);
    rdata(clip(av));
    send(ACS_CMD_WRITE_MUX, 8'h45);
    wait_idle;
    @(negedge ref_clk) cmp_val(fully_settled, 1'b0);
    for (n = 1; n < 9; n++) begin
      wait_fall(t0);
      @(negedge ref_clk);
      if (fully_settled === 1'b1) break;
    end
    cmp_cnt(n, STEP, STEP + 1);
    @(posedge ref_clk);
    stall <= 1'b1;
    repeat (3) rdata(clip(av));
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) cmp_val(cmd_ready, 1'b0);
    @(posedge ref_clk);
    stall <= 1'b0;
    wait_idle;
    repeat (4) @(posedge ref_clk);
    cmp_cnt(exp_q.size(), 0, 0);
    send(ACS_CMD_WRITE_RATE, 8'h55);
    wait_idle;
    @(negedge ref_clk) cmp_val(rate_select_register, 8'hF0);
    send(ACS_CMD_WRITE_RATE, 8'hE0);
    send(ACS_CMD_SYNC, 8'h00);
    send(ACS_CMD_WAKEUP, 8'h00);
    wait_idle;
    @(negedge ref_clk) cmp_val(rate_select_register, 8'hE0);
    wait_fall(t0);
    wait_fall(n);
    cmp_cnt(n - t0, 2 * PER, 2 * PER);
    send(ACS_CMD_STANDBY, 8'h00);
    test_done();
  end
endmodule
